// File: apmlvc_defines.svh
`ifndef APMLVC_DEFINES_SVH
`define APMLVC_DEFINES_SVH

// Register offsets (16-bit registers)
`define APMLVC_OFS_POWER_MODE   8'h0f
`define APMLVC_OFS_DRIVE        8'h11
`define APMLVC_OFS_TERM         8'h12
`define APMLVC_OFS_DATA_SLEEP   8'h52

// Power mode control fields
`define APMLVC_QUAD_SLEEP_LSB   0
`define APMLVC_DUAL_SLEEP_LSB   4
`define APMLVC_SINGLE_SLEEP_BIT 6
`define APMLVC_DEEP_SLEEP_BIT   8
`define APMLVC_POWER_OFF_BIT    9
`define APMLVC_PIN_FUNC_LSB     10

// Drive current fields
`define APMLVC_DRV_BITCLK_LSB   0
`define APMLVC_DRV_FRAME_LSB    4
`define APMLVC_DRV_DATA_LSB     8

// Termination fields
`define APMLVC_TRM_BITCLK_LSB   0
`define APMLVC_TRM_FRAME_LSB    4
`define APMLVC_TRM_DATA_LSB     8
`define APMLVC_TRM_ENABLE_BIT   14

// Data output sleep behaviour field
`define APMLVC_DATA_ZERO_BIT    0

// Writable masks; other bits read as zero
`define APMLVC_MASK_POWER_MODE  16'h0f7f
`define APMLVC_MASK_DRIVE       16'h0777
`define APMLVC_MASK_TERM        16'h4777
`define APMLVC_MASK_DATA_SLEEP  16'h0001

// Reset value of every register
`define APMLVC_REG_RESET        16'h0000

// Pin function codes
`define APMLVC_PIN_FUNC_OFF     2'h0
`define APMLVC_PIN_FUNC_DEEP    2'h2

// Default drive current, tenths of a milliamp
`define APMLVC_DRIVE_DEFAULT_DMA 7'h23

`endif

// File: apmlvc_pkg.sv
package apmlvc_pkg;

   // Converter channel arrangement chosen elsewhere in the device
   typedef enum logic [1:0] {
      SETUP_SINGLE = 2'b01,
      SETUP_DUAL   = 2'b10,
      SETUP_QUAD   = 2'b11
   } apmlvc_setup_t;

   // Chip-wide power state
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_LIGHT  = 2'b01,
      PWR_DEEP   = 2'b10,
      PWR_OFF    = 2'b11
   } apmlvc_pwr_t;

   // Driver current setting of one output group
   typedef struct packed {
      logic [2:0] code;
      logic [6:0] tenths_ma;
   } apmlvc_drive_t;

   // Internal termination setting of one output group
   typedef struct packed {
      logic [2:0] code;
      logic [8:0] ohms;
   } apmlvc_term_t;

   // Whole module state
   typedef struct packed {
      logic [15:0]   power_mode_control;
      logic [15:0]   output_drive_current;
      logic [15:0]   output_termination_control;
      logic [15:0]   output_sleep_behaviour;
      logic [15:0]   rdata;
      apmlvc_pwr_t   pwr;
      logic [3:0]    ch_sleep;
      logic          ref_off;
      logic          clk_oe_n;
      logic          clk_toggle;
      logic [3:0]    data_oe_n;
      logic [3:0]    data_zero;
      apmlvc_drive_t drv_bitclk;
      apmlvc_drive_t drv_frame;
      apmlvc_drive_t drv_data;
      logic          term_en;
      apmlvc_term_t  trm_bitclk;
      apmlvc_term_t  trm_frame;
      apmlvc_term_t  trm_data;
   } apmlvc_state_t;

endpackage : apmlvc_pkg

// File: apmlvc_power_lvds_cfg.sv
`timescale 1ns/1ns
`default_nettype none
`include "apmlvc_defines.svh"

module apmlvc_power_lvds_cfg (
   // Clock and reset
   input  wire logic                   CORE_CLK,
   input  wire logic                   ARST_N,
   // Register write and read port
   input  wire logic                   REG_WR_EN,
   input  wire logic                   REG_RD_EN,
   input  wire logic [7:0]             REG_ADDR,
   input  wire logic [15:0]            REG_WDATA,
   output logic      [15:0]            REG_RDATA,
   // Device context
   input  wire apmlvc_pkg::apmlvc_setup_t CHANNEL_SETUP,
   input  wire logic                   EXTERNAL_OFF_PIN,
   // Power controls
   output apmlvc_pkg::apmlvc_pwr_t     POWER_STATE,
   output logic      [3:0]             ADC_CH_SLEEP,
   output logic                        REF_POWER_OFF,
   // Clock output drivers
   output logic                        CLK_OUT_OE_N,
   output logic                        CLK_TOGGLE_EN,
   // Data output drivers, one per converter channel
   output logic      [3:0]             DATA_OUT_OE_N,
   output logic      [3:0]             DATA_OUT_ZERO,
   // Driver current per output group
   output apmlvc_pkg::apmlvc_drive_t   BIT_CLK_DRIVE,
   output apmlvc_pkg::apmlvc_drive_t   FRAME_CLOCK_OUT_DRIVE,
   output apmlvc_pkg::apmlvc_drive_t   DATA_DRIVE,
   // Internal termination per output group
   output logic                        TERM_ENABLE,
   output apmlvc_pkg::apmlvc_term_t    BIT_CLK_TERM,
   output apmlvc_pkg::apmlvc_term_t    FRAME_CLOCK_OUT_TERM,
   output apmlvc_pkg::apmlvc_term_t    DATA_TERM
);

   apmlvc_pkg::apmlvc_state_t s_r;
   apmlvc_pkg::apmlvc_state_t s_nxt;

   // Driver current in tenths of a milliamp; 010 and 101 are the RSDS and 6.5 mA rows
   function automatic apmlvc_pkg::apmlvc_drive_t drive_decode(input logic [2:0] code);
      apmlvc_pkg::apmlvc_drive_t d;
      d.code = code;
      unique case (code)
         3'h0: d.tenths_ma = `APMLVC_DRIVE_DEFAULT_DMA;
         3'h1: d.tenths_ma = 7'h19;
         3'h2: d.tenths_ma = 7'h0f;
         3'h3: d.tenths_ma = 7'h05;
         3'h4: d.tenths_ma = 7'h4b;
         3'h5: d.tenths_ma = 7'h41;
         3'h6: d.tenths_ma = 7'h37;
         3'h7: d.tenths_ma = 7'h2d;
      endcase
      return d;
   endfunction : drive_decode

   // Termination code gated by the enable; ohms zero means open
   function automatic apmlvc_pkg::apmlvc_term_t term_decode(input logic       en,
                                                            input logic [2:0] field);
      apmlvc_pkg::apmlvc_term_t t;
      t.code = en ? field : 3'h0;
      unique case (t.code)
         3'h0: t.ohms = 9'h000;
         3'h1: t.ohms = 9'h104;
         3'h2: t.ohms = 9'h096;
         3'h3: t.ohms = 9'h05e;
         3'h4: t.ohms = 9'h07d;
         3'h5: t.ohms = 9'h050;
         3'h6: t.ohms = 9'h042;
         3'h7: t.ohms = 9'h037;
      endcase
      return t;
   endfunction : term_decode

   // Local views of the stored fields
   logic [3:0] quad_channel_light_sleep;
   logic [1:0] dual_channel_light_sleep;
   logic       single_channel_light_sleep;
   logic       deep_sleep_req;
   logic       full_power_off;
   logic [1:0] off_pin_function;
   logic       data_out_sleep_behaviour;
   logic [3:0] reg_ch_sleep;
   logic       pin_light;
   logic       pin_deep;
   logic       pin_off;

   assign quad_channel_light_sleep   = s_r.power_mode_control[`APMLVC_QUAD_SLEEP_LSB +: 4];
   assign dual_channel_light_sleep   = s_r.power_mode_control[`APMLVC_DUAL_SLEEP_LSB +: 2];
   assign single_channel_light_sleep = s_r.power_mode_control[`APMLVC_SINGLE_SLEEP_BIT];
   assign deep_sleep_req             = s_r.power_mode_control[`APMLVC_DEEP_SLEEP_BIT];
   assign full_power_off             = s_r.power_mode_control[`APMLVC_POWER_OFF_BIT];
   assign off_pin_function           = s_r.power_mode_control[`APMLVC_PIN_FUNC_LSB +: 2];
   assign data_out_sleep_behaviour   = s_r.output_sleep_behaviour[`APMLVC_DATA_ZERO_BIT];

   // Pin maps onto whole-chip modes only, never single channels
   assign pin_light = EXTERNAL_OFF_PIN && off_pin_function[0];
   assign pin_deep  = EXTERNAL_OFF_PIN && (off_pin_function == `APMLVC_PIN_FUNC_DEEP);
   assign pin_off   = EXTERNAL_OFF_PIN && (off_pin_function == `APMLVC_PIN_FUNC_OFF);

   // Register sleep bits per converter channel for the current setup
   always_comb begin
      unique case (CHANNEL_SETUP)
         apmlvc_pkg::SETUP_SINGLE: reg_ch_sleep = {3'h0, single_channel_light_sleep};
         apmlvc_pkg::SETUP_DUAL:   reg_ch_sleep = {2'h0, dual_channel_light_sleep};
         apmlvc_pkg::SETUP_QUAD:   reg_ch_sleep = quad_channel_light_sleep;
         default:                  reg_ch_sleep = quad_channel_light_sleep;
      endcase
   end

   // Next state: register writes, readback and all driver controls
   always_comb begin
      s_nxt = s_r;
      // Writes; reserved bits are masked so they read back as zero
      if (REG_WR_EN) begin
         unique case (REG_ADDR)
            `APMLVC_OFS_POWER_MODE:
               s_nxt.power_mode_control = REG_WDATA & `APMLVC_MASK_POWER_MODE;
            `APMLVC_OFS_DRIVE:
               s_nxt.output_drive_current = REG_WDATA & `APMLVC_MASK_DRIVE;
            `APMLVC_OFS_TERM:
               s_nxt.output_termination_control = REG_WDATA & `APMLVC_MASK_TERM;
            `APMLVC_OFS_DATA_SLEEP:
               s_nxt.output_sleep_behaviour = REG_WDATA & `APMLVC_MASK_DATA_SLEEP;
            default: ;
         endcase
      end
      // Readback of stored fields; unmapped offsets read zero
      if (REG_RD_EN) begin
         unique case (REG_ADDR)
            `APMLVC_OFS_POWER_MODE: s_nxt.rdata = s_r.power_mode_control;
            `APMLVC_OFS_DRIVE:      s_nxt.rdata = s_r.output_drive_current;
            `APMLVC_OFS_TERM:       s_nxt.rdata = s_r.output_termination_control;
            `APMLVC_OFS_DATA_SLEEP: s_nxt.rdata = s_r.output_sleep_behaviour;
            default:                s_nxt.rdata = 16'h0000;
         endcase
      end

      // Power state: off beats deep beats light
      if (full_power_off || pin_off) begin
         s_nxt.pwr = apmlvc_pkg::PWR_OFF;
      end else if (deep_sleep_req || pin_deep) begin
         s_nxt.pwr = apmlvc_pkg::PWR_DEEP;
      end else if (pin_light || (reg_ch_sleep != 4'h0)) begin
         s_nxt.pwr = apmlvc_pkg::PWR_LIGHT;
      end else begin
         s_nxt.pwr = apmlvc_pkg::PWR_ACTIVE;
      end

      // Driver controls follow the new power state
      unique case (s_nxt.pwr)
         apmlvc_pkg::PWR_ACTIVE: begin
            s_nxt.ch_sleep   = 4'h0;
            s_nxt.ref_off    = 1'b0;
            s_nxt.clk_oe_n   = 1'b0;
            s_nxt.clk_toggle = 1'b1;
            s_nxt.data_oe_n  = 4'h0;
            s_nxt.data_zero  = 4'h0;
         end
         apmlvc_pkg::PWR_LIGHT: begin
            // Only sleeping channels touch their data lanes
            s_nxt.ch_sleep   = pin_light ? 4'hf : reg_ch_sleep;
            s_nxt.ref_off    = 1'b0;
            s_nxt.clk_oe_n   = 1'b0;
            s_nxt.clk_toggle = 1'b1;
            s_nxt.data_oe_n  = data_out_sleep_behaviour ? 4'h0 : s_nxt.ch_sleep;
            s_nxt.data_zero  = data_out_sleep_behaviour ? s_nxt.ch_sleep : 4'h0;
         end
         apmlvc_pkg::PWR_DEEP: begin
            s_nxt.ch_sleep   = 4'hf;
            s_nxt.ref_off    = 1'b0;
            s_nxt.clk_oe_n   = 1'b0;
            s_nxt.clk_toggle = 1'b1;
            s_nxt.data_oe_n  = data_out_sleep_behaviour ? 4'h0 : 4'hf;
            s_nxt.data_zero  = data_out_sleep_behaviour ? 4'hf : 4'h0;
         end
         apmlvc_pkg::PWR_OFF: begin
            // Receiver loses lock here; nothing drives
            s_nxt.ch_sleep   = 4'hf;
            s_nxt.ref_off    = 1'b1;
            s_nxt.clk_oe_n   = 1'b1;
            s_nxt.clk_toggle = 1'b0;
            s_nxt.data_oe_n  = 4'hf;
            s_nxt.data_zero  = 4'h0;
         end
      endcase

      // Driver current and termination from the stored fields
      s_nxt.drv_bitclk = drive_decode(
         s_r.output_drive_current[`APMLVC_DRV_BITCLK_LSB +: 3]);
      s_nxt.drv_frame  = drive_decode(s_r.output_drive_current[`APMLVC_DRV_FRAME_LSB +: 3]);
      s_nxt.drv_data   = drive_decode(s_r.output_drive_current[`APMLVC_DRV_DATA_LSB +: 3]);
      s_nxt.term_en    = s_r.output_termination_control[`APMLVC_TRM_ENABLE_BIT];
      s_nxt.trm_bitclk = term_decode(s_nxt.term_en,
         s_r.output_termination_control[`APMLVC_TRM_BITCLK_LSB +: 3]);
      s_nxt.trm_frame  = term_decode(s_nxt.term_en,
         s_r.output_termination_control[`APMLVC_TRM_FRAME_LSB +: 3]);
      s_nxt.trm_data   = term_decode(s_nxt.term_en,
         s_r.output_termination_control[`APMLVC_TRM_DATA_LSB +: 3]);
   end

   // State register; reset gives all-active, default drive, no termination
   always_ff @(posedge CORE_CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         s_r                            <= '0;
         s_r.power_mode_control         <= `APMLVC_REG_RESET;
         s_r.output_drive_current       <= `APMLVC_REG_RESET;
         s_r.output_termination_control <= `APMLVC_REG_RESET;
         s_r.output_sleep_behaviour     <= `APMLVC_REG_RESET;
         s_r.clk_toggle                 <= 1'b1;
         s_r.drv_bitclk.tenths_ma       <= `APMLVC_DRIVE_DEFAULT_DMA;
         s_r.drv_frame.tenths_ma        <= `APMLVC_DRIVE_DEFAULT_DMA;
         s_r.drv_data.tenths_ma         <= `APMLVC_DRIVE_DEFAULT_DMA;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs taken straight from the state register
   assign REG_RDATA             = s_r.rdata;
   assign POWER_STATE           = s_r.pwr;
   assign ADC_CH_SLEEP          = s_r.ch_sleep;
   assign REF_POWER_OFF         = s_r.ref_off;
   assign CLK_OUT_OE_N          = s_r.clk_oe_n;
   assign CLK_TOGGLE_EN         = s_r.clk_toggle;
   assign DATA_OUT_OE_N         = s_r.data_oe_n;
   assign DATA_OUT_ZERO         = s_r.data_zero;
   assign BIT_CLK_DRIVE         = s_r.drv_bitclk;
   assign FRAME_CLOCK_OUT_DRIVE = s_r.drv_frame;
   assign DATA_DRIVE            = s_r.drv_data;
   assign TERM_ENABLE           = s_r.term_en;
   assign BIT_CLK_TERM          = s_r.trm_bitclk;
   assign FRAME_CLOCK_OUT_TERM  = s_r.trm_frame;
   assign DATA_TERM             = s_r.trm_data;

   // Checks on the driven outputs
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!ARST_N);

   sequence s_wr_deep_only;
      REG_WR_EN && (REG_ADDR == `APMLVC_OFS_POWER_MODE) && REG_WDATA[`APMLVC_DEEP_SLEEP_BIT]
         && !REG_WDATA[`APMLVC_POWER_OFF_BIT];
   endsequence
   sequence s_pin_quiet_two;
      !EXTERNAL_OFF_PIN [*2];
   endsequence

   property p_drive_default;
      (s_r.output_drive_current[2:0] == 3'h0) |=>
         (BIT_CLK_DRIVE.tenths_ma == `APMLVC_DRIVE_DEFAULT_DMA);
   endproperty
   a_drive_default: assert property (p_drive_default) else $error("drive not 3.5 mA");

   property p_term_gate;
      !s_r.output_termination_control[`APMLVC_TRM_ENABLE_BIT] |=>
         (BIT_CLK_TERM.ohms == 9'h000) && (FRAME_CLOCK_OUT_TERM.ohms == 9'h000)
         && (DATA_TERM.ohms == 9'h000);
   endproperty
   a_term_gate: assert property (p_term_gate) else $error("termination while disabled");

   // Watches the stored field, so a broken 000 entry of the decode table is caught
   property p_term_zero;
      s_r.output_termination_control[`APMLVC_TRM_ENABLE_BIT]
         && (s_r.output_termination_control[`APMLVC_TRM_DATA_LSB +: 3] == 3'h0)
         |=> TERM_ENABLE && (DATA_TERM.code == 3'h0) && (DATA_TERM.ohms == 9'h000);
   endproperty
   a_term_zero: assert property (p_term_zero) else $error("code 000 not open");

   property p_quad_sleep;
      (CHANNEL_SETUP == apmlvc_pkg::SETUP_QUAD) && (s_r.power_mode_control[9:8] == 2'h0)
         && !EXTERNAL_OFF_PIN |=> (ADC_CH_SLEEP == $past(quad_channel_light_sleep));
   endproperty
   a_quad_sleep: assert property (p_quad_sleep) else $error("quad sleep mismatch");

   property p_dual_sleep;
      (CHANNEL_SETUP == apmlvc_pkg::SETUP_DUAL) && (s_r.power_mode_control[9:8] == 2'h0)
         && !EXTERNAL_OFF_PIN |=> (ADC_CH_SLEEP == {2'h0, $past(dual_channel_light_sleep)});
   endproperty
   a_dual_sleep: assert property (p_dual_sleep) else $error("dual sleep mismatch");

   property p_deep_write;
      s_wr_deep_only ##1 s_pin_quiet_two |-> (POWER_STATE == apmlvc_pkg::PWR_DEEP)
         && (ADC_CH_SLEEP == 4'hf) && !CLK_OUT_OE_N;
   endproperty
   a_deep_write: assert property (p_deep_write) else $error("deep sleep not entered");

   property p_off_clocks;
      (POWER_STATE == apmlvc_pkg::PWR_OFF) |-> CLK_OUT_OE_N && REF_POWER_OFF && !CLK_TOGGLE_EN;
   endproperty
   a_off_clocks: assert property (p_off_clocks) else $error("clocks driven when off");

   property p_sleep_clocks;
      (POWER_STATE inside {apmlvc_pkg::PWR_LIGHT, apmlvc_pkg::PWR_DEEP}) |->
         !CLK_OUT_OE_N && CLK_TOGGLE_EN;
   endproperty
   a_sleep_clocks: assert property (p_sleep_clocks) else $error("clocks off in sleep");

   property p_pin_light;
      EXTERNAL_OFF_PIN && off_pin_function[0] && (s_r.power_mode_control[9:8] == 2'h0)
         |=> (ADC_CH_SLEEP == 4'hf) && (POWER_STATE == apmlvc_pkg::PWR_LIGHT);
   endproperty
   a_pin_light: assert property (p_pin_light) else $error("pin light sleep missing");

   property p_pin_deep;
      EXTERNAL_OFF_PIN && (off_pin_function == `APMLVC_PIN_FUNC_DEEP) && !full_power_off
         |=> (POWER_STATE == apmlvc_pkg::PWR_DEEP) && (ADC_CH_SLEEP == 4'hf);
   endproperty
   a_pin_deep: assert property (p_pin_deep) else $error("pin deep sleep missing");

   property p_pin_off;
      EXTERNAL_OFF_PIN && (off_pin_function == 2'h0) |=> (POWER_STATE == apmlvc_pkg::PWR_OFF);
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin power-off missing");

   property p_data_hiz;
      (POWER_STATE == apmlvc_pkg::PWR_DEEP) && !$past(data_out_sleep_behaviour) |->
         (DATA_OUT_OE_N == 4'hf) && (DATA_OUT_ZERO == 4'h0);
   endproperty
   a_data_hiz: assert property (p_data_hiz) else $error("data lanes not high-Z");

   property p_light_zero;
      (POWER_STATE == apmlvc_pkg::PWR_LIGHT) && $past(data_out_sleep_behaviour) |->
         (DATA_OUT_OE_N == 4'h0) && (DATA_OUT_ZERO == ADC_CH_SLEEP);
   endproperty
   a_light_zero: assert property (p_light_zero) else $error("data lanes not zero");

endmodule : apmlvc_power_lvds_cfg

`default_nettype wire

// File: apmlvc_rx_model.sv
`timescale 1ns/1ns
`default_nettype none

// Far-end receiver: keeps word lock only while both clocks are driven and toggling
module apmlvc_rx_model (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       arst_n,
   // Clock pair state seen at the receiver pins
   input  wire logic       clk_oe_n,
   input  wire logic       clk_toggle_en,
   // Lock status
   output logic            rx_sync
);
   // Lock drops one edge after the clock pair floats; no lock inside reset
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_sync <= 1'b0;
      end else begin
         rx_sync <= !clk_oe_n && clk_toggle_en;
      end
   end
endmodule : apmlvc_rx_model

`default_nettype wire

// File: apmlvc_power_lvds_cfg_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "apmlvc_defines.svh"

`define CHK(got, exp) \
   begin check_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp); end end

module apmlvc_power_lvds_cfg_tb;
   typedef struct packed {
      logic [15:0] r0f;
      logic        r52;
      logic        pin;
      logic [1:0]  setup;
      logic [1:0]  pwr;
      logic [3:0]  sl;
      logic [3:0]  ctl;
      logic [3:0]  doe;
      logic [3:0]  dz;
   } apmlvc_row_t;

   logic                       core_clk, arst_n, wr_en, rd_en, off_pin, rx_sync;
   logic [7:0]                 addr;
   logic [15:0]                wdata, rdata, rv;
   apmlvc_pkg::apmlvc_setup_t  setup;
   apmlvc_pkg::apmlvc_pwr_t    pwr;
   logic [3:0]                 ch_sleep, doe_n, dzero;
   logic                       ref_off, clk_oe_n, clk_tog, term_en;
   apmlvc_pkg::apmlvc_drive_t  drv_b, drv_f, drv_d;
   apmlvc_pkg::apmlvc_term_t   trm_b, trm_f, trm_d;
   int                         fail_count, check_count;
   logic [17:0]                row_obs;
   logic [6:0]                 ma [8] = '{7'h23, 7'h19, 7'h0f, 7'h05, 7'h4b, 7'h41, 7'h37, 7'h2d};
   logic [8:0]                 ohm [8] = '{9'h000, 9'h104, 9'h096, 9'h05e, 9'h07d, 9'h050,
                                           9'h042, 9'h037};
   // Light sleep, deep sleep, power-off, pin mapping and the OR of both sources
   apmlvc_row_t rows [16] = '{
      '{16'h0005, 1'h0, 1'h0, 2'h3, 2'h1, 4'h5, 4'h5, 4'h5, 4'h0},
      '{16'h0005, 1'h1, 1'h0, 2'h3, 2'h1, 4'h5, 4'h5, 4'h0, 4'h5},
      '{16'h0020, 1'h0, 1'h0, 2'h3, 2'h0, 4'h0, 4'h5, 4'h0, 4'h0},
      '{16'h0010, 1'h0, 1'h0, 2'h2, 2'h1, 4'h1, 4'h5, 4'h1, 4'h0},
      '{16'h0040, 1'h0, 1'h0, 2'h1, 2'h1, 4'h1, 4'h5, 4'h1, 4'h0},
      '{16'h0100, 1'h0, 1'h0, 2'h3, 2'h2, 4'hf, 4'h5, 4'hf, 4'h0},
      '{16'h0100, 1'h1, 1'h0, 2'h3, 2'h2, 4'hf, 4'h5, 4'h0, 4'hf},
      '{16'h0200, 1'h1, 1'h0, 2'h3, 2'h3, 4'hf, 4'ha, 4'hf, 4'h0},
      '{16'h0000, 1'h0, 1'h1, 2'h3, 2'h3, 4'hf, 4'ha, 4'hf, 4'h0},
      '{16'h0400, 1'h0, 1'h1, 2'h3, 2'h1, 4'hf, 4'h5, 4'hf, 4'h0},
      '{16'h0c00, 1'h1, 1'h1, 2'h3, 2'h1, 4'hf, 4'h5, 4'h0, 4'hf},
      '{16'h0800, 1'h0, 1'h1, 2'h3, 2'h2, 4'hf, 4'h5, 4'hf, 4'h0},
      '{16'h0801, 1'h0, 1'h0, 2'h3, 2'h1, 4'h1, 4'h5, 4'h1, 4'h0},
      '{16'h0402, 1'h0, 1'h1, 2'h3, 2'h1, 4'hf, 4'h5, 4'hf, 4'h0},
      '{16'h0500, 1'h0, 1'h1, 2'h3, 2'h2, 4'hf, 4'h5, 4'hf, 4'h0},
      '{16'h0000, 1'h0, 1'h0, 2'h3, 2'h0, 4'h0, 4'h5, 4'h0, 4'h0}};

   apmlvc_power_lvds_cfg apmlvc_power_lvds_cfg_i (
      .CORE_CLK(core_clk), .ARST_N(arst_n), .REG_WR_EN(wr_en), .REG_RD_EN(rd_en),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .CHANNEL_SETUP(setup),
      .EXTERNAL_OFF_PIN(off_pin), .POWER_STATE(pwr), .ADC_CH_SLEEP(ch_sleep),
      .REF_POWER_OFF(ref_off), .CLK_OUT_OE_N(clk_oe_n), .CLK_TOGGLE_EN(clk_tog),
      .DATA_OUT_OE_N(doe_n), .DATA_OUT_ZERO(dzero), .BIT_CLK_DRIVE(drv_b),
      .FRAME_CLOCK_OUT_DRIVE(drv_f), .DATA_DRIVE(drv_d), .TERM_ENABLE(term_en),
      .BIT_CLK_TERM(trm_b), .FRAME_CLOCK_OUT_TERM(trm_f), .DATA_TERM(trm_d));

   apmlvc_rx_model apmlvc_rx_model_i (
      .core_clk(core_clk), .arst_n(arst_n), .clk_oe_n(clk_oe_n),
      .clk_toggle_en(clk_tog), .rx_sync(rx_sync));

   // Power outputs in the order of the row fields, lock status included
   assign row_obs = {pwr, ch_sleep, clk_oe_n, clk_tog, ref_off, rx_sync, doe_n, dzero};

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // Strobes are dropped at the edge that takes them, never earlier
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk);
      wr_en <= 1'b1; addr <= a; wdata <= d;
      @(posedge core_clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      rd_en <= 1'b1; addr <= a;
      @(posedge core_clk);
      rd_en <= 1'b0;
      @(posedge core_clk);
      #1 rv = rdata;
   endtask : rd

   // Field stored at the write edge, outputs one edge later, lock one more; one spare edge
   task automatic settle();
      repeat (3) @(posedge core_clk);
      #1;
   endtask : settle

   task automatic reset_pulse();
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      settle();
   endtask : reset_pulse

   task automatic check_reset();
      foreach (rows[k]) begin
         if (k < 4) begin
            rd(k == 0 ? 8'h0f : k == 1 ? 8'h11 : k == 2 ? 8'h12 : 8'h52);
            `CHK(rv, 16'h0000)
         end
      end
      `CHK({pwr, clk_oe_n, clk_tog, doe_n}, {2'h0, 1'h0, 1'h1, 4'h0})
      `CHK({drv_b, trm_d}, {3'h0, 7'h23, 12'h000})
   endtask : check_reset

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   // Hang guard
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      wrap_up();
   end

   initial begin
      fail_count = 0; check_count = 0;
      arst_n = 1'b0; wr_en = 1'b0; rd_en = 1'b0; addr = 8'h00; wdata = 16'h0000;
      off_pin = 1'b0; setup = apmlvc_pkg::SETUP_QUAD;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      settle();
      check_reset();
      foreach (rows[i]) begin
         @(posedge core_clk);
         off_pin <= rows[i].pin;
         setup <= apmlvc_pkg::apmlvc_setup_t'(rows[i].setup);
         wr(`APMLVC_OFS_DATA_SLEEP, {15'h0000, rows[i].r52});
         wr(`APMLVC_OFS_POWER_MODE, rows[i].r0f);
         settle();
         `CHK(row_obs[17:8], rows[i][17:8])
         `CHK(row_obs[7:0], rows[i][7:0])
         rd(`APMLVC_OFS_POWER_MODE);
         `CHK(rv, rows[i].r0f)
      end
      // Every drive and termination code on all three groups at once
      for (int c = 0; c < 8; c++) begin
         wr(`APMLVC_OFS_DRIVE, {5'h00, c[2:0], 1'h0, c[2:0], 1'h0, c[2:0]});
         wr(`APMLVC_OFS_TERM, {5'h08, c[2:0], 1'h0, c[2:0], 1'h0, c[2:0]});
         settle();
         `CHK({drv_b, drv_f, drv_d}, {3{c[2:0], ma[c]}})
         `CHK({term_en, trm_b, trm_f, trm_d}, {1'h1, {3{c[2:0], ohm[c]}}})
      end
      // Distinct codes per group; termination fields held off without the enable
      wr(`APMLVC_OFS_DRIVE, 16'h0421);
      wr(`APMLVC_OFS_TERM, 16'h0123);
      settle();
      `CHK({drv_b.code, drv_f.code, drv_d.code}, {3'h1, 3'h2, 3'h4})
      `CHK({term_en, trm_b, trm_d}, {1'h0, 24'h000000})
      wr(`APMLVC_OFS_TERM, 16'h4123);
      settle();
      `CHK({trm_b.code, trm_f.code, trm_d.code}, {3'h3, 3'h2, 3'h1})
      // Reserved bits dropped, unmapped offset reads zero
      wr(`APMLVC_OFS_POWER_MODE, 16'hffff);
      wr(8'h20, 16'hffff);
      rd(`APMLVC_OFS_POWER_MODE);
      `CHK(rv, 16'h0f7f)
      rd(8'h20);
      `CHK(rv, 16'h0000)
      // Reset in mid-run returns every field to zero
      reset_pulse();
      check_reset();
      wrap_up();
   end
endmodule : apmlvc_power_lvds_cfg_tb

`default_nettype wire
